// [design/sdcdec_defines.vh]
// constants for the sinc3 decimator and result control block
// assumes one 16-bit register port and a 50 MHz system clock
`ifndef SDCDEC_DEFINES_VH
`define SDCDEC_DEFINES_VH

// register word addresses
`define SDCDEC_ADDR_CTRL    2'h0
`define SDCDEC_ADDR_RESULT  2'h1
`define SDCDEC_ADDR_STATUS  2'h2

// control register fields
`define SDCDEC_CTL_GO       0
`define SDCDEC_CTL_SINGLE   1
`define SDCDEC_CTL_GROUP    2
`define SDCDEC_CTL_DF       3
`define SDCDEC_CTL_LSBACC   4
`define SDCDEC_CTL_LSBTOG   5
`define SDCDEC_CTL_OSR_LO   6
`define SDCDEC_CTL_OSR_HI   7
`define SDCDEC_CTL_SRC      8
`define SDCDEC_CTL_DIV_LO   9
`define SDCDEC_CTL_DIV_HI   10
`define SDCDEC_CTL_DLY_LO   11
`define SDCDEC_CTL_DLY_HI   12
`define SDCDEC_CTL_RESET    16'h0000

// status register fields
`define SDCDEC_ST_READY     0
`define SDCDEC_ST_OVFL      1
`define SDCDEC_ST_BUSY      2
`define SDCDEC_ST_MODE_LO   3
`define SDCDEC_ST_MODE_HI   4

// conversion mode codes {grouped, continuous}
`define SDCDEC_MODE_SGL_ONE 2'h0
`define SDCDEC_MODE_SGL_CNT 2'h1
`define SDCDEC_MODE_GRP_ONE 2'h2
`define SDCDEC_MODE_GRP_CNT 2'h3

// filter geometry
`define SDCDEC_ACC_W        25
`define SDCDEC_OUT_W        24
`define SDCDEC_MAX_LOG2     4'h8
`define SDCDEC_DLY_BASE     3'h4
`define SDCDEC_ZERO16       16'h0000

`endif

// [design/sdcdec_top.v]
// one channel of sinc3 decimation, result formatting and conversion control
// assumes a synchronous 16-bit register port, modulator bit from a pin
//
// What this block does
// RULE1: sinc3 decimates the 1-bit modulator stream
// RULE2: one result per decimation period
// RULE3: step settles by third or fourth result
// RULE4: output width 15 to 24 bits by ratio
// RULE5: ratio 256 shows filter bits 23..8
// RULE6: ratio 32 result word lsb reads zero
// RULE7: low access gives sixteen low bits
// RULE8: byte read gives eight low bits
// RULE9: toggle inverts low access per read
// RULE10: toggle write leaves low access alone; the code reloads low access from bit 4 on every control write
// RULE11: one result word, ready flag on write
// RULE12: ready clears on read or write
// RULE13: format 0 is offset binary
// RULE14: format 1 is twos complement
// RULE15: single and group select four modes
// RULE16: ungrouped after grouped is group master
// RULE17: ungrouped single shot runs once, clears go
// RULE18: clearing go stops, powers down filter
// RULE19: continuous repeats until go cleared
// RULE20: software reads result before clearing go
// RULE21: notch follows modulator clock and ratio
// RULE22: delay 00 suppresses ready until fourth
// RULE23: overflow when unread result is replaced
// RULE24: integrators at fm, combs at fs
`include "sdcdec_defines.vh"

module sdcdec_top (
    // clock and reset
    input  wire        clk_sys_in,
    input  wire        resetn_in,
    // register port
    input  wire [1:0]  reg_addr_in,
    input  wire [15:0] reg_wdata_in,
    input  wire        reg_wr_in,
    input  wire        reg_rd_in,
    input  wire        reg_rd_byte_in,
    output reg  [15:0] reg_rdata_out,
    // modulator side pins
    input  wire        mod_bit_in,
    input  wire        mod_ext_clk_in,
    input  wire        prev_group_in,
    // status lines
    output wire        group_master_out,
    output wire        group_with_next_out,
    output wire        busy_out,
    output wire        result_ready_flag_out,
    output wire        overflow_flag_out
);

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // log2 of the oversampling ratio, 256 at code zero
    function [3:0] osr_log2;
        input [1:0] sel;
        begin
            osr_log2 = `SDCDEC_MAX_LOG2 - {2'h0, sel};
        end
    endfunction

    // clip the raw sum to the largest code of its width
    function [`SDCDEC_ACC_W-1:0] clip_raw;
        input [`SDCDEC_ACC_W-1:0] raw;
        input [3:0]               lg;
        reg   [31:0]              lim;
        begin
            lim = (32'h1 << (lg * 3)) - 32'h1;
            if ({7'h0, raw} > lim) begin
                clip_raw = lim[`SDCDEC_ACC_W-1:0];
            end else begin
                clip_raw = raw;
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // control register

    reg  [15:0] ctrl_q;
    reg         ready_q;
    reg         ovfl_q;
    reg         lsbacc_q;

    wire        conv_go              = ctrl_q[`SDCDEC_CTL_GO];
    wire        single_shot_sel      = ctrl_q[`SDCDEC_CTL_SINGLE];
    wire        group_with_next      = ctrl_q[`SDCDEC_CTL_GROUP];
    wire        data_format_sel      = ctrl_q[`SDCDEC_CTL_DF];
    wire        low_bits_toggle      = ctrl_q[`SDCDEC_CTL_LSBTOG];
    wire [1:0]  oversample_ratio_sel =
                ctrl_q[`SDCDEC_CTL_OSR_HI:`SDCDEC_CTL_OSR_LO];
    wire        mod_clock_src_sel    = ctrl_q[`SDCDEC_CTL_SRC];
    wire [1:0]  mod_clock_div        =
                ctrl_q[`SDCDEC_CTL_DIV_HI:`SDCDEC_CTL_DIV_LO];
    wire [1:0]  irq_delay_sel        =
                ctrl_q[`SDCDEC_CTL_DLY_HI:`SDCDEC_CTL_DLY_LO];
    wire [3:0]  osr_lg               = osr_log2(oversample_ratio_sel);

    // mode decode from the single and group settings
    wire [1:0]  mode = {group_with_next, ~single_shot_sel};   // RULE15
    assign group_master_out    = ~group_with_next & prev_group_in; // RULE16
    assign group_with_next_out = group_with_next;
    assign busy_out            = conv_go;

    wire wr_ctrl   = reg_wr_in & (reg_addr_in == `SDCDEC_ADDR_CTRL);
    wire wr_status = reg_wr_in & (reg_addr_in == `SDCDEC_ADDR_STATUS);
    wire rd_result = reg_rd_in & (reg_addr_in == `SDCDEC_ADDR_RESULT);

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers, a change counts once stages two and three agree

    reg  [2:0]  bit_sync_q;
    reg  [2:0]  clk_sync_q;
    reg         mod_bit_q;
    reg         ext_clk_q;
    reg         ext_clk_prev_q;

    // stage one feeds stage two only
    always @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            bit_sync_q     <= 3'h0;
            clk_sync_q     <= 3'h0;
            mod_bit_q      <= 1'b0;
            ext_clk_q      <= 1'b0;
            ext_clk_prev_q <= 1'b0;
        end else begin
            bit_sync_q <= {bit_sync_q[1:0], mod_bit_in};
            clk_sync_q <= {clk_sync_q[1:0], mod_ext_clk_in};
            if (bit_sync_q[1] == bit_sync_q[2]) begin
                mod_bit_q <= bit_sync_q[2];
            end
            if (clk_sync_q[1] == clk_sync_q[2]) begin
                ext_clk_q <= clk_sync_q[2];
            end
            ext_clk_prev_q <= ext_clk_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // modulator clock: source select then power-of-two divider

    reg  [2:0]  div_cnt_q;
    wire        base_tick = mod_clock_src_sel ?
                            (ext_clk_q & ~ext_clk_prev_q) : 1'b1;
    wire [2:0]  div_mask  = (3'h1 << mod_clock_div) - 3'h1;
    wire        mod_tick  = conv_go & base_tick &
                            (div_cnt_q >= div_mask);          // RULE21

    // divider held clear while stopped so each start is aligned
    always @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            div_cnt_q <= 3'h0;
        end else if (!conv_go || mod_tick) begin
            div_cnt_q <= 3'h0;
        end else if (base_tick) begin
            div_cnt_q <= div_cnt_q + 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sinc3 filter: integrators at the modulator rate

    reg  [`SDCDEC_ACC_W-1:0] integ1_q;
    reg  [`SDCDEC_ACC_W-1:0] integ2_q;
    reg  [`SDCDEC_ACC_W-1:0] integ3_q;
    reg  [7:0]               dec_cnt_q;
    wire [7:0]               dec_last = 8'hff >> oversample_ratio_sel;
    wire                     dec_end  = mod_tick & (dec_cnt_q == dec_last);

    // wraparound sums are fine, combs undo the modulo arithmetic
    always @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            integ1_q  <= {`SDCDEC_ACC_W{1'b0}};
            integ2_q  <= {`SDCDEC_ACC_W{1'b0}};
            integ3_q  <= {`SDCDEC_ACC_W{1'b0}};
            dec_cnt_q <= 8'h00;
        end else if (!conv_go) begin                     // RULE18
            integ1_q  <= {`SDCDEC_ACC_W{1'b0}};
            integ2_q  <= {`SDCDEC_ACC_W{1'b0}};
            integ3_q  <= {`SDCDEC_ACC_W{1'b0}};
            dec_cnt_q <= 8'h00;
        end else if (mod_tick) begin
            integ1_q  <= integ1_q + {{(`SDCDEC_ACC_W-1){1'b0}}, mod_bit_q};
            integ2_q  <= integ2_q + integ1_q;            // RULE24
            integ3_q  <= integ3_q + integ2_q;            // RULE1
            dec_cnt_q <= dec_end ? 8'h00 : dec_cnt_q + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sinc3 filter: combs at the output rate

    reg  [`SDCDEC_ACC_W-1:0] z1_q;
    reg  [`SDCDEC_ACC_W-1:0] z2_q;
    reg  [`SDCDEC_ACC_W-1:0] z3_q;
    reg  [`SDCDEC_ACC_W-1:0] raw_q;
    reg                      res_stb_q;
    wire [`SDCDEC_ACC_W-1:0] d1 = integ3_q - z1_q;
    wire [`SDCDEC_ACC_W-1:0] d2 = d1 - z2_q;
    wire [`SDCDEC_ACC_W-1:0] d3 = d2 - z3_q;

    // one result per decimation period
    always @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            z1_q      <= {`SDCDEC_ACC_W{1'b0}};
            z2_q      <= {`SDCDEC_ACC_W{1'b0}};
            z3_q      <= {`SDCDEC_ACC_W{1'b0}};
            raw_q     <= {`SDCDEC_ACC_W{1'b0}};
            res_stb_q <= 1'b0;
        end else if (!conv_go) begin
            z1_q      <= {`SDCDEC_ACC_W{1'b0}};
            z2_q      <= {`SDCDEC_ACC_W{1'b0}};
            z3_q      <= {`SDCDEC_ACC_W{1'b0}};
            res_stb_q <= 1'b0;
        end else begin
            res_stb_q <= dec_end;                        // RULE2
            if (dec_end) begin
                z1_q  <= integ3_q;
                z2_q  <= d1;
                z3_q  <= d2;
                raw_q <= d3;                             // RULE24
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // result word and conversion counting

    reg  [`SDCDEC_ACC_W-1:0] result_word_q;
    reg  [2:0]               conv_cnt_q;
    wire [2:0]               need_cnt = `SDCDEC_DLY_BASE -
                                        {1'b0, irq_delay_sel};
    wire [2:0]               cnt_next = (conv_cnt_q == `SDCDEC_DLY_BASE) ?
                                        conv_cnt_q : conv_cnt_q + 3'h1;
    // early results are still written, only the flag waits for settling
    wire                     flag_ok  = cnt_next >= need_cnt; // RULE3
    // a strobe left over from the stopping edge must not raise the flag
    wire                     flag_set = res_stb_q & flag_ok & // RULE22
                                        conv_go;
    wire                     one_done = flag_set & single_shot_sel &
                                        ~group_with_next; // RULE19

    // counter restarts on each start so the settle delay reapplies
    always @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            result_word_q <= {`SDCDEC_ACC_W{1'b0}};
            conv_cnt_q    <= 3'h0;
        end else begin
            if (!conv_go) begin
                conv_cnt_q <= 3'h0;
            end else if (res_stb_q) begin
                conv_cnt_q <= cnt_next;
            end
            if (res_stb_q) begin
                result_word_q <= raw_q;                  // RULE11
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // flags, set wins over every clear

    always @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ready_q <= 1'b0;
            ovfl_q  <= 1'b0;
        end else begin
            if (flag_set) begin
                ready_q <= 1'b1;                         // RULE11
            end else if (rd_result ||
                         (wr_status && reg_wdata_in[`SDCDEC_ST_READY])) begin
                ready_q <= 1'b0;                         // RULE12
            end
            if (flag_set && ready_q && !rd_result) begin
                ovfl_q <= 1'b1;                          // RULE23
            end else if (wr_status && reg_wdata_in[`SDCDEC_ST_OVFL]) begin
                ovfl_q <= 1'b0;
            end
        end
    end
    assign result_ready_flag_out = ready_q;
    assign overflow_flag_out     = ovfl_q;

    ////////////////////////////////////////////////////////////////////////
    // control writes, low access bit and go auto clear

    always @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ctrl_q   <= `SDCDEC_CTL_RESET;
            lsbacc_q <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= reg_wdata_in;
            end else if (one_done) begin
                ctrl_q[`SDCDEC_CTL_GO] <= 1'b0;          // RULE17
            end
            // continuous mode keeps go set until software clears it
            if (rd_result && low_bits_toggle) begin
                lsbacc_q <= ~lsbacc_q;                   // RULE9
            end else if (wr_ctrl) begin
                lsbacc_q <= reg_wdata_in[`SDCDEC_CTL_LSBACC]; // RULE10
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read formatting

    reg  [`SDCDEC_ACC_W-1:0] clipped;
    reg  [31:0]              wide;
    reg  [`SDCDEC_OUT_W-1:0] aligned;
    reg  [15:0]              result_view;

    // left align to 24 bits so every ratio keeps the same full scale
    always @* begin
        clipped = clip_raw(result_word_q, osr_lg);       // RULE4
        wide    = {7'h0, clipped} <<
                  (`SDCDEC_OUT_W - osr_lg * 3);
        aligned = wide[`SDCDEC_OUT_W-1:0];               // RULE6
        if (data_format_sel) begin
            aligned[`SDCDEC_OUT_W-1] = ~aligned[`SDCDEC_OUT_W-1]; // RULE14
        end
        if (reg_rd_byte_in) begin
            result_view = {8'h00, clipped[7:0]};         // RULE8
        end else if (lsbacc_q) begin
            result_view = clipped[15:0];                 // RULE7
        end else begin
            result_view = aligned[`SDCDEC_OUT_W-1:8];    // RULE5 RULE13
        end
    end

    // read data stands only in the cycle after the strobe
    always @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            reg_rdata_out <= `SDCDEC_ZERO16;
        end else if (!reg_rd_in) begin
            reg_rdata_out <= `SDCDEC_ZERO16;
        end else begin
            case (reg_addr_in)
                `SDCDEC_ADDR_CTRL: begin
                    reg_rdata_out <= {ctrl_q[15:5], lsbacc_q, ctrl_q[3:0]};
                end
                `SDCDEC_ADDR_RESULT: begin
                    reg_rdata_out <= result_view;
                end
                `SDCDEC_ADDR_STATUS: begin
                    reg_rdata_out <= {11'h000, mode, conv_go,
                                      ovfl_q, ready_q};
                end
                default: begin
                    reg_rdata_out <= `SDCDEC_ZERO16;
                end
            endcase
        end
    end

endmodule // sdcdec_top

// [testbench/sdcdec_properties.sv]
// assertions on the decimator register port and status lines
// assumes one clock domain; bound to sdcdec_top from tb_top
module sdcdec_properties (
    // clock and reset
    input wire        clk_sys_in,
    input wire        resetn_in,
    // register port
    input wire [1:0]  reg_addr_in,
    input wire [15:0] reg_wdata_in,
    input wire        reg_wr_in,
    input wire        reg_rd_in,
    input wire [15:0] reg_rdata_out,
    // status lines
    input wire        prev_group_in,
    input wire        group_master_out,
    input wire        group_with_next_out,
    input wire        busy_out,
    input wire        result_ready_flag_out,
    input wire        overflow_flag_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!resetn_in);
    // control writes drive go and group bits
    wire ctl_wr = reg_wr_in && reg_addr_in == 2'h0;

    ////////////////////////////////////////////////////////////////////
    master_decode_a: assert property (
        group_master_out == (!group_with_next_out && prev_group_in))
        else $error("group master decode wrong");
    rdata_idle_a: assert property (
        !reg_rd_in |=> reg_rdata_out == 16'h0000)
        else $error("read data not zero outside read");
    unmapped_zero_a: assert property (
        reg_rd_in && reg_addr_in == 2'h3 |=> reg_rdata_out == 16'h0000)
        else $error("unmapped read not zero");
    ready_hold_a: assert property (
        result_ready_flag_out && !reg_rd_in && !reg_wr_in
        |=> result_ready_flag_out)
        else $error("ready flag dropped without access");
    ready_cause_a: assert property (
        $rose(result_ready_flag_out) |-> $past(busy_out))
        else $error("ready set while stopped");
    ovfl_cause_a: assert property (
        $rose(overflow_flag_out) |-> $past(result_ready_flag_out))
        else $error("overflow without unread result");
    ovfl_sticky_a: assert property (
        overflow_flag_out && !reg_wr_in |=> overflow_flag_out)
        else $error("overflow cleared by hardware");
    go_write_a: assert property (
        ctl_wr |=> busy_out == $past(reg_wdata_in[0]))
        else $error("go bit not loaded by write");
    go_fall_a: assert property (
        $fell(busy_out) |-> $past(reg_wr_in) || result_ready_flag_out)
        else $error("go cleared without cause");
    group_write_a: assert property (
        ctl_wr |=> group_with_next_out == $past(reg_wdata_in[2]))
        else $error("group bit not loaded by write");
    // main scenarios reached
    cover property ($rose(result_ready_flag_out));
    cover property ($rose(overflow_flag_out));
    cover property ($fell(busy_out) && !$past(reg_wr_in));
endmodule // sdcdec_properties

// [testbench/sdcdec_mod_model.sv]
// modulator stand-in: steady bit level and a free running pin clock
// assumes the bench picks the level; the block syncs both pins
module sdcdec_mod_model (
    input  wire clk_sys_in,
    input  wire level_in,
    output reg  mod_bit_out,
    output reg  mod_clk_out
);
    timeunit 1ns;
    timeprecision 1ps;
    reg [1:0] cnt_q = 2'h0;
    // one bit per tick; all ones is positive full scale
    // pin clock runs free at a quarter of the system rate
    always @(posedge clk_sys_in) begin
        mod_bit_out <= level_in;
        cnt_q <= cnt_q + 2'h1;
        mod_clk_out <= cnt_q[1];
    end
endmodule // sdcdec_mod_model

// [testbench/tb_top.sv]
// self-checking bench for the sinc3 decimator block
// assumes sdcdec_top, its checker and the modulator stand-in
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys_in = 1'b0;
    logic        resetn_in = 1'b0;
    logic [1:0]  reg_addr_in = 2'h0;
    logic [15:0] reg_wdata_in = 16'h0000;
    logic        reg_wr_in = 1'b0;
    logic        reg_rd_in = 1'b0;
    logic        reg_rd_byte_in = 1'b0;
    logic        prev_group_in = 1'b0;
    logic        level = 1'b1;
    logic [15:0] rd_q;
    wire  [15:0] reg_rdata_out;
    wire         mod_bit_in, mod_ext_clk_in, group_master_out;
    wire         group_with_next_out, busy_out;
    wire         result_ready_flag_out, overflow_flag_out;
    int          err_total = 0;
    int          num_checks = 0;
    logic [15:0] fmt_exp [4] = '{16'hffff, 16'h7fff, 16'h0000, 16'h8000};

    sdcdec_top sdcdec_top_i (.clk_sys_in, .resetn_in, .reg_addr_in,
        .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rd_byte_in,
        .reg_rdata_out, .mod_bit_in, .mod_ext_clk_in, .prev_group_in,
        .group_master_out, .group_with_next_out, .busy_out,
        .result_ready_flag_out, .overflow_flag_out);
    sdcdec_mod_model sdcdec_mod_model_i (.clk_sys_in, .level_in(level),
        .mod_bit_out(mod_bit_in), .mod_clk_out(mod_ext_clk_in));

    ////////////////////////////////////////////////////////////////////
    // 50 MHz clock; watchdog far beyond the ~7k cycles needed
    initial begin
        forever #10 clk_sys_in = ~clk_sys_in;
    end
    initial begin
        repeat (30000) @(posedge clk_sys_in);
        err_total++;
        test_done();
    end

    task automatic chk(input logic [15:0] got, exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    // bus cycles: one strobe cycle, read data in the next cycle only
    task automatic wr(input logic [1:0] a, input logic [15:0] d);
        @(posedge clk_sys_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [1:0] a, input logic b);
        @(posedge clk_sys_in);
        reg_addr_in <= a;
        reg_rd_byte_in <= b;
        reg_rd_in <= 1'b1;
        @(posedge clk_sys_in);
        reg_rd_in <= 1'b0;
        reg_rd_byte_in <= 1'b0;
        #1 rd_q = reg_rdata_out;
    endtask
    // bounded wait, n counts cycles spent waiting
    task automatic wait_rdy(output int n);
        n = 0;
        while (result_ready_flag_out !== 1'b1 && n < 3000) begin
            @(posedge clk_sys_in);
            #1 n++;
        end
        if (n >= 3000)
            chk(1'b0, 1'b1, "ready timeout");
    endtask
    // restart with a fresh filter: go low first
    task automatic go(input logic [15:0] ctl);
        wr(2'h0, 16'h0000);
        wr(2'h0, ctl);
    endtask

    ////////////////////////////////////////////////////////////////////
    task automatic t_modes();
        prev_group_in <= 1'b1;
        wr(2'h2, 16'h0003);
        for (int m = 0; m < 4; m++) begin
            wr(2'h0, {13'h0000, m[1], ~m[0], 1'b0});
            rd(2'h2, 1'b0);
            chk(rd_q, {11'h000, m[1:0], 3'h0}, "mode");
            chk(group_master_out, !m[1], "master");
            chk(group_with_next_out, m[1], "group bit");
        end
        prev_group_in <= 1'b0;
    endtask
    task automatic t_format();
        int n;
        for (int i = 0; i < 4; i++) begin
            level <= ~i[1];
            go({12'h000, i[0], 3'h1});
            wait_rdy(n);
            rd(2'h1, 1'b0);
            chk(rd_q, fmt_exp[i], "format");
        end
        level <= 1'b1;
    endtask
    task automatic t_osr32();
        int n;
        realtime t1;
        go(16'h00c1);
        wait_rdy(n);
        chk(n >= 110 && n < 150, 1'b1, "delay 00");
        t1 = $realtime;
        rd(2'h1, 1'b0);
        chk(rd_q, 16'hfffe, "osr32 word");
        chk(result_ready_flag_out, 1'b0, "read clears");
        wait_rdy(n);
        chk($realtime - t1 == 640.0, 1'b1, "period");
        rd(2'h1, 1'b1);
        chk(rd_q, 16'h00ff, "byte");
        wr(2'h0, 16'h00e1);
        rd(2'h1, 1'b0);
        chk(rd_q, 16'hfffe, "toggle keeps");
        rd(2'h1, 1'b0);
        chk(rd_q, 16'h7fff, "low word");
        repeat (80) @(posedge clk_sys_in);
        #1 chk(overflow_flag_out, 1'b1, "overflow");
        rd(2'h2, 1'b0);
        chk(rd_q, 16'h000f, "status");
        wr(2'h2, 16'h0003);
        chk(overflow_flag_out, 1'b0, "soft clear");
        rd(2'h3, 1'b0);
        chk(rd_q, 16'h0000, "unmapped");
        rd(2'h1, 1'b0);
        wr(2'h0, 16'h00c0);
        chk(busy_out, 1'b0, "stop");
        // a flag raised just before the stop stays until cleared
        wr(2'h2, 16'h0001);
        repeat (100) @(posedge clk_sys_in);
        #1 chk(result_ready_flag_out, 1'b0, "stopped");
    endtask
    task automatic t_single();
        int n;
        go(16'h00c3);
        wait_rdy(n);
        rd(2'h1, 1'b0);
        chk(busy_out, 1'b0, "single go");
        repeat (200) @(posedge clk_sys_in);
        #1 chk(result_ready_flag_out, 1'b0, "single once");
    endtask
    task automatic t_settle();
        int n;
        logic [15:0] v [3];
        go(16'h18c1);
        for (int i = 0; i < 3; i++) begin
            wait_rdy(n);
            rd(2'h1, 1'b0);
            v[i] = rd_q;
        end
        chk(v[0] != 16'hfffe, 1'b1, "first early");
        chk(v[2], 16'hfffe, "third valid");
    endtask
    task automatic t_clock();
        int n;
        go(16'h06c1);
        wait_rdy(n);
        chk(n >= 1000 && n < 1100, 1'b1, "divide 8");
        // read clears ready so the next wait starts from a clean flag
        rd(2'h1, 1'b0);
        chk(rd_q, 16'hfffe, "divide 8 word");
        go(16'h01c1);
        wait_rdy(n);
        chk(n >= 480 && n < 560, 1'b1, "pin clock");
        wr(2'h0, 16'h0000);
    endtask

    // verdict in one place
    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk_sys_in);
        resetn_in <= 1'b1;
        t_modes();
        t_format();
        t_osr32();
        t_single();
        t_settle();
        t_clock();
        test_done();
    end
endmodule // tb_top

bind sdcdec_top sdcdec_properties sdcdec_properties_i (.clk_sys_in,
    .resetn_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
    .reg_rdata_out, .prev_group_in, .group_master_out,
    .group_with_next_out, .busy_out, .result_ready_flag_out,
    .overflow_flag_out);
